// ===== hdl/imem_ctrl_pkg.sv
// Shared constants, types and carriers of the instruction memory control block
package imem_ctrl_pkg;

	// ==========================================================
	// Register map and control field layout
	localparam int unsigned REG_AW = 8;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STAT = 8'h04;
	localparam logic [7:0] OFS_CLR  = 8'h08;
	localparam logic [7:0] OFS_IEN  = 8'h0C;
	localparam int unsigned BIT_PAGE_EN = 1;
	localparam int unsigned BIT_CRES    = 2;
	localparam int unsigned BIT_LOCK_LO = 3;
	localparam int unsigned BIT_LPRST   = 13;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [31:0] CTRL_WMASK = 32'h0000_207E;

	// ==========================================================
	// Interrupt events
	localparam int unsigned NUM_EV    = 3;
	localparam int unsigned EV_FETCH  = 0;
	localparam int unsigned EV_DATA   = 1;
	localparam int unsigned EV_NOVICT = 2;

	// ==========================================================
	// Cache geometry
	localparam int unsigned NUM_SETS = 32;
	localparam int unsigned NUM_WAYS = 4;
	localparam int unsigned SET_LO   = 5;
	localparam int unsigned SET_HI   = 9;

	// ==========================================================
	// Address map, upper bound exclusive
	localparam logic [31:0] ISRAM_LO = 32'hFFA0_0000;
	localparam logic [31:0] ISRAM_HI = 32'hFFA1_0000;
	localparam logic [31:0] IBANK_LO = 32'hFFA1_0000;
	localparam logic [31:0] IBANK_HI = 32'hFFA1_4000;
	localparam logic [31:0] ISPC_HI  = 32'hFFB0_0000;
	localparam logic [31:0] DATA_LO  = 32'hFF80_0000;
	localparam logic [31:0] MMR_LO   = 32'hFFC0_0000;

	typedef enum logic [2:0] {
		RG_EXT   = 3'h0,
		RG_ISRAM = 3'h1,
		RG_IBANK = 3'h3,
		RG_UNPOP = 3'h2,
		RG_DATA  = 3'h6,
		RG_MMR   = 3'h7
	} region_e;

	// Bank organisation, Gray along SRAM -> cache -> locked
	typedef enum logic [1:0] {
		MODE_SRAM   = 2'h0,
		MODE_CACHE  = 2'h1,
		MODE_LOCKED = 2'h3
	} mode_e;

	typedef struct packed {
		logic       valid;
		logic       prio;
		logic [1:0] age;
	} line_s;

	typedef struct packed {
		logic        valid;
		logic [31:0] addr;
		logic        pageHit;
		logic        pageCacheable;
	} fetch_req_s;

	typedef struct packed {
		logic cacheable;
		logic exception;
	} fetch_resp_s;

	typedef struct packed {
		logic       valid;
		logic [4:0] set;
		logic       pagePrio;
	} fill_req_s;

	typedef struct packed {
		logic       done;
		logic [1:0] way;
		logic       noVictim;
	} fill_resp_s;

	typedef struct packed {
		logic       valid;
		logic [4:0] set;
		logic [1:0] way;
	} line_op_s;

endpackage

// ===== hdl/imem_region_decode.sv
// Address classifier for the instruction memory checks
`timescale 1ns/1ps
`default_nettype none
module imem_region_decode
	import imem_ctrl_pkg::*;
(
	input  wire logic [31:0] addr,
	output region_e          region
);
	// Ordered compare, most specific window first
	always_comb begin
		if (addr >= ISRAM_LO && addr < ISRAM_HI) begin
			region = RG_ISRAM;
		end else if (addr >= IBANK_LO && addr < IBANK_HI) begin
			region = RG_IBANK;
		end else if (addr >= IBANK_HI && addr < ISPC_HI) begin
			region = RG_UNPOP;
		end else if (addr >= DATA_LO && addr < ISRAM_LO) begin
			region = RG_DATA;
		end else if (addr >= MMR_LO) begin
			region = RG_MMR;
		end else begin
			region = RG_EXT;
		end
	end
endmodule
`default_nettype wire

// ===== hdl/imem_victim_select.sv
// Replacement way choice for one cache set
`timescale 1ns/1ps
`default_nettype none
module imem_victim_select
	import imem_ctrl_pkg::*;
(
	input  wire line_s [NUM_WAYS-1:0] lines,
	input  wire logic [NUM_WAYS-1:0] lockMask,
	output logic [1:0]           victim,
	output logic                 none
);
	logic [NUM_WAYS-1:0] invalid;
	logic [NUM_WAYS-1:0] cand;
	logic [NUM_WAYS-1:0] lowCand;
	logic [NUM_WAYS-1:0] pool;

	// Per-way candidacy; locked ways never take part
	genvar w;
	generate
		for (w = 0; w < NUM_WAYS; w++) begin : gWay
			assign invalid[w] = ~lines[w].valid & ~lockMask[w];
			assign cand[w]    = ~lockMask[w];
			assign lowCand[w] = cand[w] & ~lines[w].prio;
		end
	endgenerate

	// Invalid way first (lowest index), then low importance, then oldest
	always_comb begin
		logic [1:0] best;
		best   = 2'h0;
		victim = 2'h0;
		pool   = (|lowCand) ? lowCand : cand;
		none   = ~|cand;
		if (|invalid) begin
			for (int i = NUM_WAYS - 1; i >= 0; i--) begin
				if (invalid[i]) begin
					victim = 2'(i);
				end
			end
		end else begin
			for (int i = 0; i < NUM_WAYS; i++) begin
				if (pool[i] && (!pool[best] || lines[i].age > lines[best].age)) begin
					best = 2'(i);
				end
			end
			victim = best;
		end
	end
endmodule
`default_nettype wire

// ===== hdl/imem_ctrl.sv
// Level-one instruction memory control: register, checks, cache state
`timescale 1ns/1ps
`default_nettype none
module imem_ctrl
	import imem_ctrl_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire logic [REG_AW-1:0] regAddr,
	input  wire logic [31:0]       regWdata,
	input  wire logic              regWe,
	input  wire logic              regRe,
	output logic [31:0]            regRdata,
	input  wire fetch_req_s        fetchReq,
	output fetch_resp_s            fetchResp,
	input  wire logic              dataValid,
	input  wire logic [31:0]       dataAddr,
	output logic                   dataExc,
	input  wire logic              dmaValid,
	input  wire logic [31:0]       dmaAddr,
	output logic                   dmaAccept,
	output logic                   dmaRefused,
	input  wire fill_req_s         fillReq,
	output fill_resp_s             fillResp,
	input  wire line_op_s          hitReq,
	input  wire line_op_s          flushReq,
	output mode_e                  bankMode,
	output logic                   irq
);

	// ==========================================================
	// State
	typedef struct packed {
		logic [31:0]                        ctrl;
		logic [NUM_EV-1:0]                  status;
		logic [NUM_EV-1:0]                  irqEn;
		logic [31:0]                        rdata;
		fetch_resp_s                        fetchResp;
		logic                               dataExc;
		logic                               dmaAccept;
		logic                               dmaRefused;
		fill_resp_s                         fillResp;
		line_s [NUM_SETS-1:0][NUM_WAYS-1:0] lines;
	} state_s;

	state_s st_q;
	state_s st_d;

	// ==========================================================
	// Field views of the control register
	logic       pageEn;
	logic       cacheRes;
	logic       lprst;
	logic [3:0] lockBits;

	assign pageEn   = st_q.ctrl[BIT_PAGE_EN];
	assign cacheRes = st_q.ctrl[BIT_CRES];
	assign lprst    = st_q.ctrl[BIT_LPRST];
	assign lockBits = st_q.ctrl[BIT_LOCK_LO +: NUM_WAYS];

	// ==========================================================
	// Address classification
	region_e fetchRegion;
	region_e dataRegion;
	region_e dmaRegion;

	imem_region_decode uFetchDec (
		.addr   (fetchReq.addr),
		.region (fetchRegion)
	);

	imem_region_decode uDataDec (
		.addr   (dataAddr),
		.region (dataRegion)
	);

	imem_region_decode uDmaDec (
		.addr   (dmaAddr),
		.region (dmaRegion)
	);

	// ==========================================================
	// Victim choice for the set being filled
	logic [1:0] victimWay;
	logic       victimNone;

	imem_victim_select uVictim (
		.lines    (st_q.lines[fillReq.set]),
		.lockMask (lockBits),
		.victim   (victimWay),
		.none     (victimNone)
	);

	// ==========================================================
	// Bank organisation as seen by the fill and fetch paths
	always_comb begin
		if (!cacheRes) begin
			bankMode = MODE_SRAM;
		end else if (|lockBits) begin
			bankMode = MODE_LOCKED;
		end else begin
			bankMode = MODE_CACHE;
		end
	end

	// ==========================================================
	// Fetch checks
	logic fetchBadSpace;
	logic fetchExc;
	logic fetchCache;

	// Minimal checking always runs, page lookup adds to it
	assign fetchBadSpace = (fetchRegion == RG_UNPOP) ||
	                       (fetchRegion == RG_DATA)  ||
	                       (fetchRegion == RG_MMR);
	// Bank is no fetch target once it is reserved as cache
	assign fetchExc = fetchReq.valid &&
	                  (fetchBadSpace ||
	                   (cacheRes && fetchRegion == RG_IBANK) ||
	                   (pageEn && !fetchReq.pageHit));
	// Reserving the bank alone does not cache anything
	assign fetchCache = fetchReq.valid && !fetchExc && cacheRes &&
	                    pageEn && fetchReq.pageCacheable &&
	                    (fetchRegion == RG_EXT);

	// ==========================================================
	// Data-side and DMA checks
	logic dataInInstr;
	logic dmaOk;

	// Data pointers never reach the instruction SRAM or the bank
	assign dataInInstr = (dataRegion == RG_ISRAM) ||
	                     (dataRegion == RG_IBANK);
	// DMA may write SRAM only, and the bank only while it is SRAM
	assign dmaOk = (dmaRegion == RG_ISRAM) ||
	               (dmaRegion == RG_IBANK && !cacheRes);

	// ==========================================================
	// Register write decode
	logic ctrlWr;
	logic clrWr;
	logic ienWr;

	assign ctrlWr = regWe && (regAddr == OFS_CTRL);
	assign clrWr  = regWe && (regAddr == OFS_CLR);
	assign ienWr  = regWe && (regAddr == OFS_IEN);

	// ==========================================================
	// Request qualifiers shared by answers and events
	logic       hitOn;
	logic       fillOn;
	logic       dataFault;
	logic       dmaTake;
	logic       dmaDeny;
	logic [1:0] ageTop;

	// Hits and fills mean nothing while the bank is plain memory
	assign hitOn     = hitReq.valid && cacheRes;
	assign fillOn    = fillReq.valid && cacheRes;

	// One expression feeds both the answer pulse and the sticky bit
	assign dataFault = dataValid && dataInInstr;

	// Exactly one DMA answer per attempt
	assign dmaTake   = dmaValid && dmaOk;
	assign dmaDeny   = dmaValid && !dmaOk;

	// Oldest age a line can reach, one step per way
	assign ageTop    = 2'(NUM_WAYS - 1);

	// ==========================================================
	// Register read selection
	logic [31:0] rdMux;

	// Status and enable sit in the low bits, the rest reads zero
	// Clear register is write-only, so reading it returns zero
	always_comb begin
		unique case (regAddr)
			OFS_CTRL: rdMux = st_q.ctrl;
			OFS_STAT: rdMux = {29'h0000_0000, st_q.status};
			OFS_IEN:  rdMux = {29'h0000_0000, st_q.irqEn};
			default:  rdMux = 32'h0000_0000;
		endcase
	end

	// ==========================================================
	// Per-way ageing for the hit set
	logic [NUM_WAYS-1:0][1:0] hitAge;
	logic [1:0]               hitOld;
	genvar                    gw;

	// Age the hit way had before this hit
	assign hitOld = st_q.lines[hitReq.set][hitReq.way].age;

	// A hit makes its way newest and pushes only the younger ones back
	generate
		for (gw = 0; gw < NUM_WAYS; gw++) begin : gHitAge
			assign hitAge[gw] = (gw == hitReq.way) ? 2'h0 :
			                    (st_q.lines[hitReq.set][gw].age < hitOld) ?
			                    st_q.lines[hitReq.set][gw].age + 2'h1 :
			                    st_q.lines[hitReq.set][gw].age;
		end
	endgenerate

	// ==========================================================
	// Per-way ageing for the set being filled
	logic [NUM_WAYS-1:0][1:0] fillBase;
	logic [NUM_WAYS-1:0][1:0] fillAge;
	logic [1:0]               fillOld;

	// An unused victim counts as oldest, so every other way below the top age ages
	assign fillOld = st_q.lines[fillReq.set][victimWay].valid ?
	                 st_q.lines[fillReq.set][victimWay].age : ageTop;

	// A same-set hit in this cycle is taken in before the fill ages the set
	generate
		for (gw = 0; gw < NUM_WAYS; gw++) begin : gFillAge
			assign fillBase[gw] = (hitOn && hitReq.set == fillReq.set) ?
			                      hitAge[gw] : st_q.lines[fillReq.set][gw].age;
			assign fillAge[gw]  = (gw == victimWay) ? 2'h0 :
			                      (st_q.lines[fillReq.set][gw].age < fillOld &&
			                       fillBase[gw] != ageTop) ?
			                      fillBase[gw] + 2'h1 : fillBase[gw];
		end
	endgenerate

	// ==========================================================
	// Next-state logic
	always_comb begin
		logic [NUM_EV-1:0] events;
		st_d   = st_q;
		events = '0;

		// Control register, reserved bits held at zero
		if (ctrlWr) begin
			st_d.ctrl = regWdata & CTRL_WMASK;
		end
		if (ienWr) begin
			st_d.irqEn = regWdata[NUM_EV-1:0];
		end

		// Read data stands one cycle after the strobe only
		st_d.rdata = regRe ? rdMux : 32'h0000_0000;

		// Per-request answers, one cycle after the request
		st_d.fetchResp.exception = fetchExc;
		st_d.fetchResp.cacheable = fetchCache;
		st_d.dataExc             = dataFault;
		st_d.dmaAccept           = dmaTake;
		st_d.dmaRefused          = dmaDeny;
		st_d.fillResp            = '0;

		// Hit: move the way to most recent, age the younger ones
		if (hitOn) begin
			for (int w = 0; w < NUM_WAYS; w++) begin
				st_d.lines[hitReq.set][w].age = hitAge[w];
			end
		end

		// Line fill into the chosen victim way
		if (fillOn) begin
			if (victimNone) begin
				st_d.fillResp.noVictim = 1'b1;
				events[EV_NOVICT]      = 1'b1;
			end else begin
				// Victim becomes newest, the rest age from the prepared view
				for (int w = 0; w < NUM_WAYS; w++) begin
					st_d.lines[fillReq.set][w].age = fillAge[w];
				end
				st_d.lines[fillReq.set][victimWay].valid = 1'b1;
				// Priority recorded only outside priority reset
				st_d.lines[fillReq.set][victimWay].prio =
					fillReq.pagePrio && !lprst;
				st_d.fillResp.done = 1'b1;
				st_d.fillResp.way  = victimWay;
			end
		end

		// Flush ignores locks; locking only guards replacement
		if (flushReq.valid) begin
			st_d.lines[flushReq.set][flushReq.way].valid = 1'b0;
			st_d.lines[flushReq.set][flushReq.way].prio  = 1'b0;
		end

		// Priority reset is a level: held, it keeps every line low
		if (lprst) begin
			for (int s = 0; s < NUM_SETS; s++) begin
				for (int w = 0; w < NUM_WAYS; w++) begin
					st_d.lines[s][w].prio = 1'b0;
				end
			end
		end

		// Sticky events; a new event beats a same-cycle clear
		events[EV_FETCH] = fetchExc;
		events[EV_DATA]  = dataFault;
		if (clrWr) begin
			st_d.status = st_q.status & ~regWdata[NUM_EV-1:0];
		end
		st_d.status = st_d.status | events;
	end

	// ==========================================================
	// Single register stage, all on the core clock
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_q       <= '0;
			st_q.ctrl  <= CTRL_RESET;
		end else begin
			st_q <= st_d;
		end
	end

	// ==========================================================
	// Outputs
	assign regRdata   = st_q.rdata;
	assign fetchResp  = st_q.fetchResp;
	assign dataExc    = st_q.dataExc;
	assign dmaAccept  = st_q.dmaAccept;
	assign dmaRefused = st_q.dmaRefused;
	assign fillResp   = st_q.fillResp;
	assign irq        = |(st_q.status & st_q.irqEn); // Level, held until cleared or its enable bit is written to zero

endmodule
`default_nettype wire

// ===== tb/imem_ctrl_props.sv
// Port checker of the instruction memory control block
`timescale 1ns/1ps
`default_nettype none
module imem_ctrl_props
	import imem_ctrl_pkg::*;
(
	input wire logic              clk,
	input wire logic              rst,
	input wire logic [REG_AW-1:0] regAddr,
	input wire logic [31:0]       regWdata,
	input wire logic              regWe,
	input wire logic              regRe,
	input wire logic [31:0]       regRdata,
	input wire fetch_req_s        fetchReq,
	input wire fetch_resp_s       fetchResp,
	input wire logic              dataValid,
	input wire logic [31:0]       dataAddr,
	input wire logic              dataExc,
	input wire logic              dmaValid,
	input wire logic [31:0]       dmaAddr,
	input wire logic              dmaAccept,
	input wire logic              dmaRefused,
	input wire fill_req_s         fillReq,
	input wire fill_resp_s        fillResp,
	input wire mode_e             bankMode,
	input wire logic              irq
);
	// ==========================================
	// One domain, so one clock and one disable
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	// Control register write, first step of every mode change
	sequence s_ctrlWr;
		regWe && regAddr == OFS_CTRL;
	endsequence

	property p_resetState;
		$fell(rst) |-> regRdata == 32'h0 && bankMode == MODE_SRAM && !irq;
	endproperty
	a_resetState: assert property (p_resetState) else $error("not idle after reset");
	property p_rdIdle;
		!$past(regRe) |-> regRdata == 32'h0;
	endproperty
	a_rdIdle: assert property (p_rdIdle) else $error("read data outside its cycle");
	property p_modeSram;
		s_ctrlWr ##0 !regWdata[BIT_CRES] |=> bankMode == MODE_SRAM;
	endproperty
	a_modeSram: assert property (p_modeSram) else $error("bank not plain memory");
	property p_modeCache;
		s_ctrlWr ##0 regWdata[BIT_CRES] && regWdata[BIT_LOCK_LO+:4] == 4'h0 |=> bankMode == MODE_CACHE;
	endproperty
	a_modeCache: assert property (p_modeCache) else $error("bank not cache");
	property p_modeLock;
		s_ctrlWr ##0 regWdata[BIT_CRES] && regWdata[BIT_LOCK_LO+:4] != 4'h0 |=> bankMode == MODE_LOCKED;
	endproperty
	a_modeLock: assert property (p_modeLock) else $error("bank not locked cache");
	property p_fetchExc;
		fetchReq.valid && fetchReq.addr >= MMR_LO |=> fetchResp.exception;
	endproperty
	a_fetchExc: assert property (p_fetchExc) else $error("register space fetch passed");
	property p_respCause;
		fetchResp.exception || fetchResp.cacheable |-> $past(fetchReq.valid);
	endproperty
	a_respCause: assert property (p_respCause) else $error("fetch answer without fetch");
	property p_dataExc;
		dataValid && dataAddr >= ISRAM_LO && dataAddr < ISRAM_HI |=> dataExc;
	endproperty
	a_dataExc: assert property (p_dataExc) else $error("data access to code passed");
	property p_dmaIsram;
		dmaValid && dmaAddr >= ISRAM_LO && dmaAddr < ISRAM_HI |=> dmaAccept && !dmaRefused;
	endproperty
	a_dmaIsram: assert property (p_dmaIsram) else $error("code write by DMA refused");
	property p_fillAns;
		fillResp.done || fillResp.noVictim |-> $past(fillReq.valid);
	endproperty
	a_fillAns: assert property (p_fillAns) else $error("fill answer without request");
endmodule
`default_nettype wire

// ===== tb/fetch_unit_model.sv
// Behavioural model of the core fetch unit
`timescale 1ns/1ps
`default_nettype none
module fetch_unit_model
	import imem_ctrl_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        go,
	input  wire logic [31:0] addr,
	input  wire logic        hit,
	input  wire logic        cach,
	output var fetch_req_s   fetchReq
);
	// ==========================================
	// One instruction fetch per go pulse, on the core clock
	// Idle cycles scramble the fields so stale values never look live
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			fetchReq <= '0;
		end else if (go) begin
			fetchReq <= '{1'b1, addr, hit, cach};
		end else begin
			fetchReq <= '{1'b0, ~fetchReq.addr, ~hit, ~cach};
		end
	end
endmodule
`default_nettype wire

// ===== tb/tb_imem_ctrl.sv
// Self-checking bench of the instruction memory control block
`timescale 1ns/1ps
`default_nettype none
module tb_imem_ctrl
	import imem_ctrl_pkg::*;
;
	// ==========================================
	// Stimulus and observed signals
	logic              clk, rst, regWe, regRe, dataValid, dmaValid, go, hit, cach, hb, cb;
	logic [REG_AW-1:0] regAddr;
	logic [31:0]       regWdata, regRdata, dataAddr, dmaAddr, fAddr, v;
	logic              dataExc, dmaAccept, dmaRefused, irq;
	logic [31:0]       adr [6];
	logic [31:0]       cfg [3];
	fetch_req_s        fetchReq;
	fetch_resp_s       fetchResp;
	fill_req_s         fillReq;
	fill_resp_s        fillResp;
	line_op_s          hitReq, flushReq;
	mode_e             bankMode;
	int                failures = 0;
	int                num_checks = 0;
	int                cyc = 0;

	imem_ctrl imem_ctrl_i (
		.clk, .rst, .regAddr, .regWdata, .regWe, .regRe, .regRdata, .fetchReq, .fetchResp,
		.dataValid, .dataAddr, .dataExc, .dmaValid, .dmaAddr, .dmaAccept, .dmaRefused,
		.fillReq, .fillResp, .hitReq, .flushReq, .bankMode, .irq
	);
	fetch_unit_model fetch_unit_model_i (
		.clk, .rst, .go, .addr(fAddr), .hit, .cach, .fetchReq
	);

	// ==========================================
	// Clock and hang guard; the run needs well under a thousand cycles
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			failures++;
			stop_test();
		end
	end

	// ==========================================
	// Compare, report and bus tasks
	task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		regAddr <= a;
		regWdata <= d;
		regWe <= 1'b1;
		@(posedge clk);
		regWe <= 1'b0;
		regWdata <= ~d;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
		@(posedge clk);
		regAddr <= a;
		regRe <= 1'b1;
		@(posedge clk);
		regRe <= 1'b0;
		#1;
		check(n, e, regRdata);
	endtask
	// Model registers the fetch, block answers one cycle later
	task automatic fetch(input logic [31:0] a, input logic h, input logic c, input logic [1:0] e);
		@(posedge clk);
		go <= 1'b1;
		fAddr <= a;
		hit <= h;
		cach <= c;
		@(posedge clk);
		go <= 1'b0;
		@(posedge clk);
		#1;
		check("fetchResp", {30'h0, e}, {30'h0, fetchResp});
	endtask
	// Direct data access (k=0) or DMA write (k=1)
	task automatic acc(input logic k, input logic [31:0] a, input logic [1:0] e);
		@(posedge clk);
		dataValid <= !k;
		dmaValid <= k;
		dataAddr <= a;
		dmaAddr <= a;
		@(posedge clk);
		dataValid <= 1'b0;
		dmaValid <= 1'b0;
		dataAddr <= ~a;
		dmaAddr <= ~a;
		#1;
		check("access", {30'h0, e}, k ? {30'h0, dmaAccept, dmaRefused} : {31'h0, dataExc});
	endtask
	// Way is meaningless when no victim exists, so it is masked then
	task automatic fill(input logic [4:0] s, input logic p, input logic [3:0] e);
		@(posedge clk);
		fillReq <= '{1'b1, s, p};
		@(posedge clk);
		fillReq <= '{1'b0, ~s, ~p};
		#1;
		check("fillResp", {28'h0, e},
			{28'h0, e[0] ? {fillResp.done, 2'b00, fillResp.noVictim} : fillResp});
	endtask
	task automatic lop(input logic f, input logic [4:0] s, input logic [1:0] w);
		@(posedge clk);
		hitReq <= '{!f, s, w};
		flushReq <= '{f, s, w};
		@(posedge clk);
		hitReq <= '0;
		flushReq <= '0;
	endtask
	function automatic logic [1:0] expFetch(input logic [31:0] a, input logic [31:0] c,
		input logic h, input logic ca);
		logic bad;
		bad = a >= MMR_LO || (a >= DATA_LO && a < ISRAM_LO) || (a >= IBANK_HI && a < ISPC_HI)
			|| (c[BIT_CRES] && a >= IBANK_LO && a < IBANK_HI) || (c[BIT_PAGE_EN] && !h);
		return {!bad && a < DATA_LO && c[BIT_CRES] && c[BIT_PAGE_EN] && ca, bad};
	endfunction

	// ==========================================
	// Main sequence
	initial begin
		{rst, regWe, regRe, dataValid, dmaValid, go, hit, cach} = 8'hFF;
		{regWe, regRe, dataValid, dmaValid, go} = 5'h0;
		{regAddr, regWdata, dataAddr, dmaAddr, fAddr} = '0;
		{fillReq, hitReq, flushReq} = '0;
		v = $urandom(99490);
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		rd(OFS_CTRL, CTRL_RESET, "ctrl");
		rd(OFS_STAT, 32'h0, "stat");
		for (int i = 0; i < 4; i++) begin
			v = $urandom & CTRL_WMASK;
			wr(OFS_CTRL, v);
			rd(OFS_CTRL, v, "ctrl");
		end
		rd(8'h10, 32'h0, "unmapped");
		rd(OFS_CLR, 32'h0, "clr");
		// Fetch checks with everything off, page check alone, then cache
		cfg = '{32'h0, 32'h2, 32'h6};
		adr = '{MMR_LO, DATA_LO, IBANK_HI, ISRAM_LO, IBANK_LO, $urandom & 32'h7FFF_FFF8};
		foreach (cfg[i]) begin
			wr(OFS_CTRL, cfg[i]);
			foreach (adr[j]) begin
				hb = 1'($urandom);
				cb = 1'($urandom);
				fetch(adr[j], hb, cb, expFetch(adr[j], cfg[i], hb, cb));
			end
		end
		check("bankMode", {30'h0, MODE_CACHE}, {30'h0, bankMode});
		acc(1'b0, ISRAM_LO + 32'h40, 2'b01);
		acc(1'b1, ISRAM_LO, 2'b10);
		acc(1'b1, IBANK_LO, 2'b01);
		// Empty set fills lowest way first, then lock ways 0 and 2
		for (int w = 0; w < 4; w++) fill(5'd3, 1'b0, {1'b1, w[1:0], 1'b0});
		wr(OFS_CTRL, 32'h6 | (32'h5 << BIT_LOCK_LO));
		fill(5'd3, 1'b0, 4'b1010);
		fill(5'd3, 1'b0, 4'b1110);
		wr(OFS_CTRL, 32'h6 | (32'hF << BIT_LOCK_LO));
		fill(5'd3, 1'b0, 4'b0001);
		lop(1'b1, 5'd3, 2'd2);
		wr(OFS_CTRL, 32'h6);
		fill(5'd3, 1'b0, 4'b1100);
		// Important way 0 survives until priorities are reset
		for (int w = 0; w < 4; w++) fill(5'd5, w == 0, {1'b1, w[1:0], 1'b0});
		lop(1'b0, 5'd5, 2'd1);
		fill(5'd5, 1'b0, 4'b1100);
		wr(OFS_CTRL, 32'h6 | (32'h1 << BIT_LPRST));
		wr(OFS_CTRL, 32'h6);
		fill(5'd5, 1'b0, 4'b1000);
		// Interrupt raised, masked, cleared
		rd(OFS_STAT, 32'h7, "stat");
		check("irq", 32'h0, {31'h0, irq});
		wr(OFS_IEN, 32'h4);
		rd(OFS_IEN, 32'h4, "ien");
		check("irq", 32'h1, {31'h0, irq});
		wr(OFS_CLR, 32'h3);
		rd(OFS_STAT, 32'h4, "stat");
		wr(OFS_CLR, 32'h4);
		rd(OFS_STAT, 32'h0, "stat");
		check("irq", 32'h0, {31'h0, irq});
		stop_test();
	end
endmodule

bind imem_ctrl imem_ctrl_props imem_ctrl_props_i (
	.clk, .rst, .regAddr, .regWdata, .regWe, .regRe, .regRdata, .fetchReq, .fetchResp,
	.dataValid, .dataAddr, .dataExc, .dmaValid, .dmaAddr, .dmaAccept, .dmaRefused,
	.fillReq, .fillResp, .bankMode, .irq
);
`default_nettype wire
